/* rtl/fsrp_pkg.sv */
/*
   Shared constants and types for the flash read, status and polling block:
   command codes, decode addresses, status bit positions, bank geometry and
   timing. Assumes a 100 MHz core clock.
*/
// Function
// [R01] both banks start in array-read mode
// [R02] protection query: three writes then one read
// [R03] query read gives 01h protected, 00h not
// [R04] status word replaces data while algorithm runs
// [R05] poll bit inverts data bit seven during program
// [R06] poll and toggle valid after fourth/sixth write
// [R07] poll bit reads zero throughout erase
// [R08] program into protected sector is ignored
// [R09] all-protected erase: zero flags, about 100us
// [R10] toggle bit inverts on each status read
// [R11] cycle done: toggling stops, array data returns
// [R12] error bit zero normally, one on failure
// [R13] error on zero-to-one program or timeout
// [R14] error bit held until flash reset command
// [R15] master stops using a failed sector; the bench erases and reprograms that sector after the flash reset
// [R16] erase-window bit zero for the window; an added sector erase sets it to one for the rest of the window
// [R17] status word bit positions seven, six, five, three
// [R18] erase gives FFh, program only clears bits
// [R19] master confirms completion by poll, toggle, busy
// [R20] master polls bit seven, rechecks on error
// [R21] master compares toggles, rechecks on error; the master model has no toggle poll, only the bit-seven poll task
// [R22] master re-reads programmed byte afterwards
// [R23] busy pin low while write or erase runs
// [R24] commands open with two unlock writes
// [R25] status only for the bank that is busy
package fsrp_pkg;
   localparam logic [7:0]  CMD_UNLOCK1      = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK2      = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM      = 8'ha0;
   localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
   localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]  CMD_BULK_ERASE   = 8'h10;
   localparam logic [7:0]  CMD_PROT_QUERY   = 8'h90;
   localparam logic [7:0]  CMD_FLASH_RESET  = 8'hf0;
   localparam logic [11:0] ADDR_UNLOCK1     = 12'h555;
   localparam logic [11:0] ADDR_UNLOCK2     = 12'haaa;
   localparam logic [1:0]  QUERY_A10        = 2'h2;
   localparam logic [7:0]  ERASED_BYTE      = 8'hff;
   localparam logic [7:0]  PROT_YES         = 8'h01;
   localparam logic [7:0]  PROT_NO          = 8'h00;
   localparam logic [7:0]  NO_SELECT_BYTE   = 8'hff;
   localparam int          POLL_BIT         = 7;
   localparam int          TOGGLE_BIT       = 6;
   localparam int          ERROR_BIT        = 5;
   localparam int          WINDOW_BIT       = 3;
   localparam int          MEM_DEPTH        = 81920;
   localparam logic [16:0] SEC_BANK_BASE    = 17'h10000;
   localparam logic [15:0] PRIM_LAST        = 16'hffff;
   localparam logic [15:0] SEC_LAST         = 16'h3fff;
   localparam logic [5:0]  PRIM_MASK        = 6'h0f;
   localparam logic [5:0]  SEC_MASK         = 6'h30;
   localparam int          TIMER_W          = 24;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          ERASE_WIN_US     = 100;
   localparam int          ERASE_WIN_CYCLES = ERASE_WIN_US * 1000 / CLK_PERIOD_NS;
   localparam int          PROT_HOLD_US     = 100;
   localparam int          PROT_HOLD_CYCLES = PROT_HOLD_US * 1000 / CLK_PERIOD_NS;
   localparam int          PROG_TIME_US     = 10;
   localparam int          PROG_CYCLES      = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int          ALGO_TIMEOUT_US  = 30000;
   localparam int          ALGO_TIMEOUT_CYCLES = ALGO_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CMD_IDLE, CMD_GOT_AA, CMD_GOT_55, CMD_PROG_DATA, CMD_ERS_AA, CMD_ERS_55, CMD_ERS_CODE
   } fsrp_cmd_t;

   typedef enum logic [2:0] {
      ENG_IDLE, ENG_PROG, ENG_ERS_WIN, ENG_ERASE, ENG_PROT_HOLD, ENG_ERROR
   } fsrp_eng_t;
endpackage : fsrp_pkg

/* rtl/fsrp_top.sv */
/*
   Flash read path, command decode and embedded program/erase engine for a
   primary bank (four sectors) and a secondary bank (two sectors).
   Assumes bus inputs synchronous to core_clk and one strobe per cycle.
*/
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fsrp_top
   import fsrp_pkg::*;
#(
   parameter int unsigned ERASE_WIN_CYC = ERASE_WIN_CYCLES,
   parameter int unsigned PROT_HOLD_CYC = PROT_HOLD_CYCLES,
   parameter int unsigned ALGO_TMO_CYC  = ALGO_TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // processor bus
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [7:0]  bus_rdata,
   // sector selects and protection straps
   input  wire logic [3:0]  primary_sector_selects,
   input  wire logic [1:0]  secondary_sector_selects,
   input  wire logic [3:0]  primary_protect,
   input  wire logic [1:0]  secondary_protect,
   // status pin
   output logic             busy_indicator_pin
);
   localparam logic [TIMER_W-1:0] WIN_LOAD  = TIMER_W'(ERASE_WIN_CYC - 1);
   localparam logic [TIMER_W-1:0] HOLD_LOAD = TIMER_W'(PROT_HOLD_CYC - 1);
   localparam logic [TIMER_W-1:0] PROG_LOAD = TIMER_W'(PROG_CYCLES - 1);
   localparam logic [TIMER_W-1:0] TMO_LAST  = TIMER_W'(ALGO_TMO_CYC - 1);

   logic [1:0]         rst_sync_reg;
   logic               rst_n;
   logic [7:0]         mem [0:MEM_DEPTH-1];
   fsrp_cmd_t          cmd_reg;
   fsrp_eng_t          eng_reg;
   logic               act_bank_reg;
   logic               op_is_prog_reg;
   logic [16:0]        prog_idx_reg;
   logic [7:0]         prog_data_reg;
   logic [7:0]         prog_old_reg;
   logic [5:0]         erase_mask_reg;
   logic [15:0]        walk_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [TIMER_W-1:0] watchdog_reg;
   logic               window_reg;
   logic               toggle_reg;
   logic               query_reg;
   logic               query_bank_reg;

   logic [5:0]  sel_all;
   logic [5:0]  prot_all;
   logic        bank_hit;
   logic        bank;
   logic [11:0] a12;
   logic [16:0] bus_idx;
   logic [16:0] walk_idx;
   logic        wr_hit;
   logic        flash_reset;
   logic        prog_go;
   logic        sect_go;
   logic        bulk_go;
   logic        query_go;
   logic        status_state;
   logic        status_rd;
   logic        query_rd;
   logic [5:0]  bank_mask;
   logic [7:0]  status_word;

   function automatic logic [16:0] mem_index(input logic b, input logic [15:0] a);
      mem_index = b ? (SEC_BANK_BASE + {3'h0, a[13:0]}) : {1'h0, a};
   endfunction : mem_index

   function automatic logic [2:0] sector_of(input logic b, input logic [15:0] a);
      sector_of = b ? {2'h2, a[13]} : {1'h0, a[15:14]};
   endfunction : sector_of

   // reset release through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   assign sel_all      = {secondary_sector_selects, primary_sector_selects};
   assign prot_all     = {secondary_protect, primary_protect};
   assign bank_hit     = |sel_all;
   assign bank         = ~(|primary_sector_selects);
   assign a12          = bus_addr[11:0];
   assign bus_idx      = mem_index(bank, bus_addr);
   assign walk_idx     = mem_index(act_bank_reg, walk_reg);
   assign bank_mask    = bank ? SEC_MASK : PRIM_MASK;
   assign wr_hit       = bus_wr && bank_hit;
   assign flash_reset  = wr_hit && (bus_wdata == CMD_FLASH_RESET);
   assign prog_go      = wr_hit && (eng_reg == ENG_IDLE) && (cmd_reg == CMD_PROG_DATA) && !flash_reset;
   assign sect_go      = wr_hit && (eng_reg == ENG_IDLE) && (cmd_reg == CMD_ERS_CODE)
                         && (bus_wdata == CMD_SECTOR_ERASE);
   assign bulk_go      = wr_hit && (eng_reg == ENG_IDLE) && (cmd_reg == CMD_ERS_CODE)
                         && (bus_wdata == CMD_BULK_ERASE) && (a12 == ADDR_UNLOCK1);
   assign query_go     = wr_hit && (eng_reg == ENG_IDLE) && (cmd_reg == CMD_GOT_55)
                         && (bus_wdata == CMD_PROT_QUERY) && (a12 == ADDR_UNLOCK1);
   assign status_state = (eng_reg == ENG_PROG) || (eng_reg == ENG_ERS_WIN)
                         || (eng_reg == ENG_ERASE) || (eng_reg == ENG_ERROR);
   assign status_rd    = bus_rd && bank_hit && (bank == act_bank_reg) && status_state; // R25
   assign query_rd     = bus_rd && bank_hit && query_reg && (bank == query_bank_reg)
                         && !bus_addr[6] && (bus_addr[1:0] == QUERY_A10);

   // status word; unguaranteed bits read as zero
   always_comb begin
      status_word             = 8'h00;
      status_word[POLL_BIT]   = op_is_prog_reg ? ~prog_data_reg[7] : 1'b0; // R05 R07 R17
      status_word[TOGGLE_BIT] = toggle_reg; // R10
      status_word[ERROR_BIT]  = (eng_reg == ENG_ERROR); // R12
      status_word[WINDOW_BIT] = window_reg; // R16
   end

   // command sequence decode; only the low twelve address bits matter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= CMD_IDLE; // R01
      end else if (wr_hit) begin
         if (flash_reset || eng_reg != ENG_IDLE) begin
            cmd_reg <= CMD_IDLE;
         end else begin
            case (cmd_reg)
               CMD_IDLE: begin
                  cmd_reg <= (a12 == ADDR_UNLOCK1 && bus_wdata == CMD_UNLOCK1) ? CMD_GOT_AA : CMD_IDLE; // R24
               end
               CMD_GOT_AA: begin
                  cmd_reg <= (a12 == ADDR_UNLOCK2 && bus_wdata == CMD_UNLOCK2) ? CMD_GOT_55 : CMD_IDLE;
               end
               CMD_GOT_55: begin
                  if (a12 == ADDR_UNLOCK1 && bus_wdata == CMD_PROGRAM) begin
                     cmd_reg <= CMD_PROG_DATA;
                  end else if (a12 == ADDR_UNLOCK1 && bus_wdata == CMD_ERASE_SETUP) begin
                     cmd_reg <= CMD_ERS_AA;
                  end else begin
                     cmd_reg <= CMD_IDLE;
                  end
               end
               CMD_ERS_AA: begin
                  cmd_reg <= (a12 == ADDR_UNLOCK1 && bus_wdata == CMD_UNLOCK1) ? CMD_ERS_55 : CMD_IDLE;
               end
               CMD_ERS_55: begin
                  cmd_reg <= (a12 == ADDR_UNLOCK2 && bus_wdata == CMD_UNLOCK2) ? CMD_ERS_CODE : CMD_IDLE;
               end
               default: begin
                  cmd_reg <= CMD_IDLE;
               end
            endcase
         end
      end
   end

   // protection query mode, left only by a flash reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         query_reg      <= 1'b0;
         query_bank_reg <= 1'b0;
      end else if (flash_reset && eng_reg == ENG_IDLE) begin
         query_reg <= 1'b0; // R01
      end else if (query_go) begin
         query_reg      <= 1'b1; // R02
         query_bank_reg <= bank;
      end
   end

   // embedded algorithm engine
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_reg        <= ENG_IDLE;
         act_bank_reg   <= 1'b0;
         op_is_prog_reg <= 1'b0;
         prog_idx_reg   <= 17'h0;
         prog_data_reg  <= 8'h00;
         prog_old_reg   <= 8'h00;
         erase_mask_reg <= 6'h0;
         walk_reg       <= 16'h0;
         timer_reg      <= '0;
         window_reg     <= 1'b1;
      end else begin
         case (eng_reg)
            ENG_IDLE: begin
               if (prog_go && !prot_all[sector_of(bank, bus_addr)]) begin // R08
                  eng_reg        <= ENG_PROG; // R06
                  act_bank_reg   <= bank;
                  op_is_prog_reg <= 1'b1;
                  prog_idx_reg   <= bus_idx;
                  prog_data_reg  <= bus_wdata;
                  prog_old_reg   <= mem[bus_idx];
                  timer_reg      <= PROG_LOAD;
               end else if (sect_go) begin
                  eng_reg        <= ENG_ERS_WIN; // R06
                  act_bank_reg   <= bank;
                  op_is_prog_reg <= 1'b0;
                  erase_mask_reg <= sel_all & bank_mask;
                  timer_reg      <= WIN_LOAD;
                  window_reg     <= 1'b0; // R16
               end else if (bulk_go) begin
                  act_bank_reg   <= bank;
                  op_is_prog_reg <= 1'b0;
                  erase_mask_reg <= bank_mask & ~prot_all;
                  walk_reg       <= 16'h0;
                  timer_reg      <= HOLD_LOAD;
                  eng_reg        <= ((bank_mask & ~prot_all) == 6'h0) ? ENG_PROT_HOLD : ENG_ERASE; // R09
               end
            end
            ENG_PROG: begin
               if (watchdog_reg == TMO_LAST) begin
                  eng_reg <= ENG_ERROR; // R13
               end else if (timer_reg == '0) begin
                  eng_reg <= ((prog_data_reg & ~prog_old_reg) != 8'h00) ? ENG_ERROR : ENG_IDLE; // R13 R11
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            ENG_ERS_WIN: begin
               if (wr_hit && bank == act_bank_reg) begin
                  if (bus_wdata == CMD_SECTOR_ERASE) begin
                     erase_mask_reg <= erase_mask_reg | (sel_all & bank_mask);
                     timer_reg      <= WIN_LOAD;
                     window_reg     <= 1'b1; // R16
                  end else begin
                     eng_reg    <= ENG_IDLE;
                     window_reg <= 1'b1;
                  end
               end else if (timer_reg == '0) begin
                  window_reg     <= 1'b1; // R16
                  walk_reg       <= 16'h0;
                  timer_reg      <= HOLD_LOAD;
                  erase_mask_reg <= erase_mask_reg & ~prot_all;
                  eng_reg        <= ((erase_mask_reg & ~prot_all) == 6'h0) ? ENG_PROT_HOLD : ENG_ERASE; // R09
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            ENG_ERASE: begin
               walk_reg <= walk_reg + 16'h1; // R18
               if (flash_reset && bank == act_bank_reg) begin
                  eng_reg <= ENG_IDLE;
               end else if (watchdog_reg == TMO_LAST) begin
                  eng_reg <= ENG_ERROR; // R13
               end else if (walk_reg == (act_bank_reg ? SEC_LAST : PRIM_LAST)) begin
                  eng_reg <= ENG_IDLE; // R11
               end
            end
            ENG_PROT_HOLD: begin
               if (timer_reg == '0) begin
                  eng_reg <= ENG_IDLE; // R09
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            ENG_ERROR: begin
               if (flash_reset && bank == act_bank_reg) begin
                  eng_reg <= ENG_IDLE; // R14
               end
            end
            default: begin
               eng_reg <= ENG_IDLE;
            end
         endcase
      end
   end

   // algorithm watchdog for program and erase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_reg <= '0;
      end else if (eng_reg == ENG_PROG || eng_reg == ENG_ERASE) begin
         watchdog_reg <= watchdog_reg + TIMER_W'(1); // R13
      end else begin
         watchdog_reg <= '0;
      end
   end

   // array starts erased; program only clears bits, erase walks the bank
   initial begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
         mem[i] = ERASED_BYTE;
      end
   end
   always_ff @(posedge core_clk) begin
      if (eng_reg == ENG_PROG && timer_reg == '0) begin
         mem[prog_idx_reg] <= prog_old_reg & prog_data_reg; // R18
      end else if (eng_reg == ENG_ERASE && erase_mask_reg[sector_of(act_bank_reg, walk_reg)]) begin
         mem[walk_idx] <= ERASED_BYTE; // R18
      end
   end

   // toggle bit flips on every status read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         toggle_reg <= 1'b0;
      end else if (status_rd) begin
         toggle_reg <= ~toggle_reg; // R10
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata <= 8'h00;
      end else if (!bus_rd) begin
         bus_rdata <= 8'h00;
      end else if (!bank_hit) begin
         bus_rdata <= NO_SELECT_BYTE;
      end else if (query_rd) begin
         bus_rdata <= (|(sel_all & prot_all)) ? PROT_YES : PROT_NO; // R03
      end else if (status_rd) begin
         bus_rdata <= status_word; // R04
      end else if (eng_reg == ENG_PROT_HOLD && bank == act_bank_reg) begin
         bus_rdata <= {4'h0, window_reg, 3'h0}; // R09
      end else begin
         bus_rdata <= mem[bus_idx]; // R01 R11
      end
   end

   // busy pin low while a write or erase runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_indicator_pin <= 1'b1;
      end else begin
         busy_indicator_pin <= !(eng_reg == ENG_PROG || eng_reg == ENG_ERS_WIN
                                 || eng_reg == ENG_ERASE || eng_reg == ENG_PROT_HOLD); // R23
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   busy_pin_low_a: assert property (eng_reg == ENG_PROG |=> !busy_indicator_pin) // R23
      else $error("busy pin not low during program");
   prot_query_a: assert property (query_rd && |(sel_all & prot_all) |=> bus_rdata == PROT_YES) // R03
      else $error("protected sector query did not read 01h");
   unprot_query_a: assert property (query_rd && !(|(sel_all & prot_all)) |=> bus_rdata == PROT_NO) // R03
      else $error("unprotected sector query did not read 00h");
   prog_poll_a: assert property (status_rd && op_is_prog_reg |=> bus_rdata[7] == ~$past(prog_data_reg[7])) // R05
      else $error("poll bit not inverted during program");
   erase_poll_a: assert property (status_rd && !op_is_prog_reg |=> !bus_rdata[7]) // R07
      else $error("poll bit not zero during erase");
   toggle_flip_a: assert property (status_rd ##1 status_rd |=> bus_rdata[6] != $past(bus_rdata[6])) // R10
      else $error("toggle bit did not invert between status reads");
   prot_prog_a: assert property (prog_go && prot_all[sector_of(bank, bus_addr)] |=> eng_reg == ENG_IDLE) // R08
      else $error("program into protected sector was started");
   error_sticky_a: assert property (eng_reg == ENG_ERROR && !flash_reset |=> eng_reg == ENG_ERROR) // R14
      else $error("error state left without flash reset");
   error_bit_a: assert property (status_rd |=> bus_rdata[5] == ($past(eng_reg) == ENG_ERROR)) // R12
      else $error("error bit does not match engine state");
   hold_flags_a: assert property (eng_reg == ENG_PROT_HOLD && bus_rd && bank_hit && bank == act_bank_reg
                                  && !query_rd |=> bus_rdata[7:6] == 2'h0) // R09
      else $error("poll or toggle not zero in protected erase hold");
   prog_clear_a: assert property (eng_reg == ENG_PROG && timer_reg == '0 && watchdog_reg != TMO_LAST
                                  |=> mem[prog_idx_reg] == (prog_old_reg & prog_data_reg)) // R18
      else $error("program did not store only cleared bits");
   window_open_a: assert property (sect_go |=> !window_reg ##1 (!window_reg || $past(wr_hit))) // R16
      else $error("erase window bit not zero after sector erase");

   prog_done_c: cover property (eng_reg == ENG_PROG ##1 eng_reg == ENG_IDLE);
   erase_run_c: cover property (eng_reg == ENG_ERS_WIN ##1 eng_reg == ENG_ERASE);
   error_c: cover property (eng_reg == ENG_PROG ##1 eng_reg == ENG_ERROR);
   query_c: cover property (query_rd);
endmodule : fsrp_top
`default_nettype wire

/* verif/fsrp_mcu.sv */
/*
   Bus master model for the flash block: byte reads and writes, unlocked
   command sequences and completion polling.
   Assumes read data arrive one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module fsrp_mcu
   import fsrp_pkg::*;
(
   // clock
   input  wire logic        core_clk,
   // processor bus
   output logic      [15:0] bus_addr,
   output logic      [7:0]  bus_wdata,
   output logic             bus_wr,
   output logic             bus_rd,
   input  wire logic [7:0]  bus_rdata,
   // sector selects, secondary in [5:4]
   output logic      [5:0]  sel
);
   initial begin
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      sel = 6'h00;
   end

   // released address and data show the inverse so stale values never match
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [5:0] s);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      sel       <= s;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr    <= 1'b0;
      bus_addr  <= ~a;
      bus_wdata <= ~d;
      sel       <= 6'h00;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [5:0] s, output logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      sel      <= s;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      bus_rd   <= 1'b0;
      bus_addr <= ~a;
      sel      <= 6'h00;
      #1 d = bus_rdata;
   endtask : rd

   // two reads with no gap between the strobes
   task automatic rd2(input logic [15:0] a, input logic [5:0] s, output logic [7:0] d0, output logic [7:0] d1);
      @(posedge core_clk);
      bus_addr <= a;
      sel      <= s;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      #1 d0 = bus_rdata;
      @(posedge core_clk);
      bus_rd   <= 1'b0;
      bus_addr <= ~a;
      sel      <= 6'h00;
      #1 d1 = bus_rdata;
   endtask : rd2

   task automatic cmd(input logic [7:0] c, input logic [5:0] s);
      wr({4'h0, ADDR_UNLOCK1}, CMD_UNLOCK1, s);
      wr({4'h0, ADDR_UNLOCK2}, CMD_UNLOCK2, s);
      wr({4'h0, ADDR_UNLOCK1}, c, s);
   endtask : cmd

   // poll bit seven, re-read once when the error bit shows
   task automatic poll(input logic [15:0] a, input logic [5:0] s, input logic b7, output logic [7:0] d);
      int n;
      n = 0;
      rd(a, s, d);
      while (d[POLL_BIT] !== b7 && d[ERROR_BIT] !== 1'b1 && n < 20000) begin
         rd(a, s, d);
         n++;
      end
      if (d[ERROR_BIT] === 1'b1)
         rd(a, s, d);
   endtask : poll
endmodule : fsrp_mcu
`default_nettype wire

/* verif/flash_read_status_polling_tb.sv */
/*
   Self-checking bench for the flash read, status and polling block.
   Assumes the bus master model drives all bus inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_read_status_polling_tb;
   import fsrp_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  bus_rdata;
   logic [5:0]  sel;
   logic        busy_indicator_pin;
   int          fail_count = 0;
   int          num_checks = 0;
   logic [7:0]  d;
   logic [7:0]  pd;
   logic [7:0]  d2;
   logic [15:0] pa;

   always #5 core_clk = ~core_clk;

   fsrp_mcu u_fsrp_mcu (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sel(sel));

   // short windows keep the run brief
   fsrp_top #(.ERASE_WIN_CYC(20), .PROT_HOLD_CYC(20), .ALGO_TMO_CYC(70000)) u_fsrp_top (
      .core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .primary_sector_selects(sel[3:0]),
      .secondary_sector_selects(sel[5:4]), .primary_protect(4'h2), .secondary_protect(2'h0),
      .busy_indicator_pin(busy_indicator_pin));

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // programming can only clear bits
   function automatic logic [7:0] stored(input logic [7:0] old, input logic [7:0] pdat);
      stored = old & pdat;
   endfunction : stored

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      #700000;
      fail_count++;
      results();
   end

   initial begin
      void'($urandom(32'h47bfe7a0));
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      pa = 16'($urandom) & 16'h1fff;
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("array after reset", d, ERASED_BYTE);
      for (int i = 0; i < 2; i++) begin
         u_fsrp_mcu.cmd(CMD_PROT_QUERY, 6'h01 << i);
         u_fsrp_mcu.rd(16'h0002, 6'h01 << i, d);
         check("protect query", d, i ? PROT_YES : PROT_NO);
         u_fsrp_mcu.wr(16'h0000, CMD_FLASH_RESET, 6'h01 << i);
      end
      // program in secondary sector 0, bit seven kept clear
      pd = 8'($urandom) & 8'h7f;
      u_fsrp_mcu.cmd(CMD_PROGRAM, 6'h10);
      u_fsrp_mcu.wr(pa, pd, 6'h10);
      u_fsrp_mcu.rd2(pa, 6'h10, d, d2);
      check("status in program", d & 8'ha8, 8'h88);
      check("toggle", (d ^ d2) & 8'h40, 8'h40);
      check("busy pin", {7'h0, busy_indicator_pin}, 8'h00);
      u_fsrp_mcu.rd(16'h4000, 6'h02, d);
      check("other bank", d, ERASED_BYTE);
      u_fsrp_mcu.poll(pa, 6'h10, pd[POLL_BIT], d);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("programmed byte", d, stored(ERASED_BYTE, pd));
      check("ready pin", {7'h0, busy_indicator_pin}, 8'h01);
      u_fsrp_mcu.cmd(CMD_PROGRAM, 6'h02);
      u_fsrp_mcu.wr(16'h4010, 8'h00, 6'h02);
      u_fsrp_mcu.rd(16'h4010, 6'h02, d);
      check("protected program", d, ERASED_BYTE);
      // raising a stored zero fails
      u_fsrp_mcu.cmd(CMD_PROGRAM, 6'h10);
      u_fsrp_mcu.wr(pa, 8'h80, 6'h10);
      u_fsrp_mcu.poll(pa, 6'h10, 1'b1, d);
      check("error flag", d & 8'h20, 8'h20);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("error held", d & 8'h20, 8'h20);
      u_fsrp_mcu.wr(pa, CMD_FLASH_RESET, 6'h10);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("after flash reset", d, stored(pd, 8'h80));
      u_fsrp_mcu.cmd(CMD_ERASE_SETUP, 6'h10);
      u_fsrp_mcu.cmd(CMD_SECTOR_ERASE, 6'h10);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("erase window open", d & 8'h88, 8'h00);
      repeat (25) @(posedge core_clk);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("erase window closed", d & 8'h88, 8'h08);
      u_fsrp_mcu.poll(pa, 6'h10, 1'b1, d);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("erased byte", d, ERASED_BYTE);
      // bulk erase of the secondary bank clears a fresh zero
      u_fsrp_mcu.cmd(CMD_PROGRAM, 6'h10);
      u_fsrp_mcu.wr(pa, 8'h00, 6'h10);
      u_fsrp_mcu.poll(pa, 6'h10, 1'b0, d);
      check("zero programmed", d, stored(ERASED_BYTE, 8'h00));
      u_fsrp_mcu.cmd(CMD_ERASE_SETUP, 6'h10);
      u_fsrp_mcu.cmd(CMD_BULK_ERASE, 6'h10);
      u_fsrp_mcu.rd(pa, 6'h10, d);
      check("bulk poll", d & 8'h80, 8'h00);
      u_fsrp_mcu.poll(pa, 6'h10, 1'b1, d);
      check("bulk erased", d, ERASED_BYTE);
      // erase naming only a protected sector
      u_fsrp_mcu.cmd(CMD_ERASE_SETUP, 6'h02);
      u_fsrp_mcu.cmd(CMD_SECTOR_ERASE, 6'h02);
      repeat (25) @(posedge core_clk);
      for (int i = 0; i < 2; i++) begin
         u_fsrp_mcu.rd(16'h4010, 6'h02, d);
         check("protected erase flags", d & 8'hc0, 8'h00);
      end
      repeat (30) @(posedge core_clk);
      u_fsrp_mcu.rd(16'h4010, 6'h02, d);
      check("protected erase data", d, ERASED_BYTE);
      results();
   end
endmodule : flash_read_status_polling_tb
`default_nettype wire
